/* File: src/sipc_defs.vh */
`ifndef SIPC_DEFS_VH
`define SIPC_DEFS_VH

// Register word indices; byte address is four times the index
`define SIPC_IDX_STATUS 8'h00
`define SIPC_IDX_MASK 8'h01
`define SIPC_IDX_PINCFG 8'h02
`define SIPC_IDX_FIFOTH 8'h06
`define SIPC_IDX_IRQST 8'h10
`define SIPC_IDX_IRQEN 8'h11

// Status / mask field positions
`define SIPC_B_SECOND 6
`define SIPC_B_FIRST 5

// Pin configuration field positions
`define SIPC_B_P1_DRV 9
`define SIPC_B_P1_POL 8
`define SIPC_B_P0_ENA 2
`define SIPC_B_P0_DRV 1
`define SIPC_B_P0_POL 0

// Reset values and writable masks
`define SIPC_RST_MASK 16'h01FF
`define SIPC_RST_PINCFG 16'h0000
`define SIPC_RST_FIFOTH 16'h0000
`define SIPC_RST_IRQEN 2'h0
`define SIPC_WMASK_PINCFG 16'h0307
`define SIPC_WMASK_FIFOTH 16'h3F00
`define SIPC_W1C_STATUS 16'h00FF

`endif

/* File: src/sipc_flag.v */
`timescale 1ns/100ps
// Sticky flag; set wins over a write-one clear
module sipc_flag (
    clk,
    reset_n,
    set,
    clr,
    flag_q
);
    input wire clk;
    input wire reset_n;
    input wire set;
    input wire clr;
    output reg flag_q;

    always @(posedge clk) begin
        if (!reset_n) begin
            flag_q <= 1'b0;
        end else if (set) begin
            flag_q <= 1'b1;
        end else if (clr) begin
            flag_q <= 1'b0;
        end
    end
endmodule

/* File: src/sipc_pin.v */
`timescale 1ns/100ps
// Pin driver: polarity, drive mode, enable
module sipc_pin (
    clk,
    reset_n,
    irq,
    pol,
    drv_od,
    ena,
    pin_o_q,
    pin_oe_n_q
);
    input wire clk;
    input wire reset_n;
    input wire irq;
    input wire pol;
    input wire drv_od;
    input wire ena;
    output reg pin_o_q;
    output reg pin_oe_n_q;

    always @(posedge clk) begin
        if (!reset_n) begin
            pin_o_q <= 1'b0;
            pin_oe_n_q <= 1'b1;
        end else begin
            pin_o_q <= irq ^ pol;
            pin_oe_n_q <= ~(ena & (~drv_od | irq));
        end
    end
endmodule

/* File: src/sipc_top.v */
`timescale 1ns/100ps
// Notes on behaviour
// [RQ1] Second-slot sample events raise an interrupt only while second_slot_irq_mask is 0; reset 1.
// [RQ2] First-slot sample events raise an interrupt only while first_slot_irq_mask is 0; reset 1.
// [RQ3] pin_one is driven always when its drive mode is 0, else only while the interrupt is asserted.
// [RQ4] pin_one is active high with polarity 0 and active low with polarity 1.
// [RQ5] pin_zero floats while pin_zero_enable is 0, whatever the interrupt state.
// [RQ6] Disabling pin_zero leaves the status register recording and reporting events.
// [RQ7] pin_zero is driven always when its drive mode is 0, else only while the interrupt is asserted.
// [RQ8] pin_zero is active high with polarity 0 and active low with polarity 1.
// [RQ9] Slot status flags read 1 after an event; writing 1 clears, writing 0 leaves them.
// [RQ10] The interrupt level is high while any pending flag has its mask bit cleared.
`include "sipc_defs.vh"

module sipc_top (
    clk,
    reset_n,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    first_slot_evt,
    second_slot_evt,
    irq_q,
    pin_zero_o,
    pin_zero_oe_n,
    pin_one_o,
    pin_one_oe_n
);
    input wire clk;
    input wire reset_n;
    input wire psel;
    input wire penable;
    input wire pwrite;
    input wire [11:0] paddr;
    input wire [31:0] pwdata;
    output reg [31:0] prdata;
    output reg pready;
    output reg pslverr;
    input wire first_slot_evt;
    input wire second_slot_evt;
    output reg irq_q;
    output wire pin_zero_o;
    output wire pin_zero_oe_n;
    output wire pin_one_o;
    output wire pin_one_oe_n;

    reg [15:0] mask_q;
    reg [15:0] mask_d;
    reg [15:0] pincfg_q;
    reg [15:0] pincfg_d;
    reg [15:0] fifoth_q;
    reg [15:0] fifoth_d;
    reg [1:0] irq_en_q;
    reg [1:0] irq_en_d;
    reg [1:0] ev_flag_q;
    reg [1:0] ev_flag_d;
    reg irq_d;
    reg [15:0] rd_d;
    reg [31:0] prdata_d;
    reg pready_d;
    reg pslverr_d;
    wire first_flag;
    wire second_flag;
    wire first_pend;
    wire second_pend;
    wire [1:0] ev_flag;
    wire [8:0] idx;
    wire setup;
    wire access;
    wire wr;
    wire hit_st;
    wire hit_mk;
    wire hit_pc;
    wire hit_ft;
    wire hit_is;
    wire hit_ie;
    wire hit_any;

    // Word index from byte address; misaligned or out-of-window addresses map nowhere
    function [8:0] word_idx;
        input [11:0] a;
        begin
            if ((a[1:0] == 2'h0) && (a[11:10] == 2'h0)) begin
                word_idx = {1'b0, a[9:2]};
            end else begin
                word_idx = 9'h1FF;
            end
        end
    endfunction

    // True when the decoded index selects the given register
    function reg_hit;
        input [8:0] i;
        input [7:0] r;
        begin
            reg_hit = (i == {1'b0, r});
        end
    endfunction

    // Sticky bits: a fresh set wins over a write-one clear
    function [1:0] w1c_upd;
        input [1:0] cur;
        input [1:0] set;
        input [1:0] clr;
        begin
            w1c_upd = set | (cur & ~clr);
        end
    endfunction

    // Only the writable bits of a register take the written value
    function [15:0] wr_merge;
        input [15:0] cur;
        input [15:0] d;
        input [15:0] m;
        begin
            wr_merge = (d & m) | (cur & ~m);
        end
    endfunction

    // Bus decode
    assign idx = word_idx(paddr);
    assign setup = psel & ~penable;
    // Writes land on the edge that completes the access phase
    assign access = psel & penable & pready;
    assign wr = access & pwrite;
    assign hit_st = reg_hit(idx, `SIPC_IDX_STATUS);
    assign hit_mk = reg_hit(idx, `SIPC_IDX_MASK);
    assign hit_pc = reg_hit(idx, `SIPC_IDX_PINCFG);
    assign hit_ft = reg_hit(idx, `SIPC_IDX_FIFOTH);
    assign hit_is = reg_hit(idx, `SIPC_IDX_IRQST);
    assign hit_ie = reg_hit(idx, `SIPC_IDX_IRQEN);
    assign hit_any = hit_st | hit_mk | hit_pc | hit_ft | hit_is | hit_ie;

    // Status flags keep recording regardless of pin state
    sipc_flag u_first (
        .clk(clk),
        .reset_n(reset_n),
        .set(first_slot_evt),
        .clr(wr & hit_st & pwdata[`SIPC_B_FIRST]),
        .flag_q(first_flag)
    ); // [RQ6] [RQ9]

    sipc_flag u_second (
        .clk(clk),
        .reset_n(reset_n),
        .set(second_slot_evt),
        .clr(wr & hit_st & pwdata[`SIPC_B_SECOND]),
        .flag_q(second_flag)
    ); // [RQ9]

    assign first_pend = first_flag & ~mask_q[`SIPC_B_FIRST]; // [RQ2]
    assign second_pend = second_flag & ~mask_q[`SIPC_B_SECOND]; // [RQ1]

    always @* begin
        irq_d = first_pend | second_pend; // [RQ10]
    end

    // Edges of the interrupt level for the wrapper status register
    assign ev_flag = {irq_d & ~irq_q, ~irq_d & irq_q};

    always @* begin
        ev_flag_d = w1c_upd(ev_flag_q, ev_flag, {2{wr & hit_is}} & pwdata[1:0]);
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            irq_q <= 1'b0;
            ev_flag_q <= 2'h0;
        end else begin
            irq_q <= irq_d; // [RQ10]
            ev_flag_q <= ev_flag_d;
        end
    end

    // Pins and irq_q are registered from one level, so they change together
    sipc_pin u_pin0 (
        .clk(clk),
        .reset_n(reset_n),
        .irq(irq_d),
        .pol(pincfg_q[`SIPC_B_P0_POL]),
        .drv_od(pincfg_q[`SIPC_B_P0_DRV]),
        .ena(pincfg_q[`SIPC_B_P0_ENA]),
        .pin_o_q(pin_zero_o),
        .pin_oe_n_q(pin_zero_oe_n)
    ); // [RQ5] [RQ7] [RQ8]

    sipc_pin u_pin1 (
        .clk(clk),
        .reset_n(reset_n),
        .irq(irq_d),
        .pol(pincfg_q[`SIPC_B_P1_POL]),
        .drv_od(pincfg_q[`SIPC_B_P1_DRV]),
        .ena(1'b1),
        .pin_o_q(pin_one_o),
        .pin_oe_n_q(pin_one_oe_n)
    ); // [RQ3] [RQ4]

    // Mask register
    always @* begin
        mask_d = mask_q;
        if (wr & hit_mk) begin
            mask_d = pwdata[15:0]; // [RQ1] [RQ2]
        end
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            mask_q <= `SIPC_RST_MASK;
        end else begin
            mask_q <= mask_d;
        end
    end

    // Pin configuration register
    always @* begin
        pincfg_d = pincfg_q;
        if (wr & hit_pc) begin
            pincfg_d = wr_merge(pincfg_q, pwdata[15:0], `SIPC_WMASK_PINCFG);
        end
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            pincfg_q <= `SIPC_RST_PINCFG;
        end else begin
            pincfg_q <= pincfg_d;
        end
    end

    // FIFO threshold: storage only in this block
    always @* begin
        fifoth_d = fifoth_q;
        if (wr & hit_ft) begin
            fifoth_d = wr_merge(fifoth_q, pwdata[15:0], `SIPC_WMASK_FIFOTH);
        end
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            fifoth_q <= `SIPC_RST_FIFOTH;
        end else begin
            fifoth_q <= fifoth_d;
        end
    end

    // Wrapper interrupt enable: storage only
    always @* begin
        irq_en_d = irq_en_q;
        if (wr & hit_ie) begin
            irq_en_d = pwdata[1:0];
        end
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            irq_en_q <= `SIPC_RST_IRQEN;
        end else begin
            irq_en_q <= irq_en_d;
        end
    end

    // Read data, chosen in the setup cycle
    always @* begin
        rd_d = 16'h0000;
        if (hit_st) begin
            rd_d[`SIPC_B_FIRST] = first_flag; // [RQ6] [RQ9]
            rd_d[`SIPC_B_SECOND] = second_flag; // [RQ9]
        end else if (hit_mk) begin
            rd_d = mask_q;
        end else if (hit_pc) begin
            rd_d = pincfg_q;
        end else if (hit_ft) begin
            rd_d = fifoth_q;
        end else if (hit_is) begin
            rd_d = {14'h0000, ev_flag_q};
        end else if (hit_ie) begin
            rd_d = {14'h0000, irq_en_q};
        end
    end

    // One wait-free answer: pready high in the access phase
    always @* begin
        pready_d = setup;
        pslverr_d = setup & ~hit_any;
        prdata_d = prdata;
        if (setup & ~pwrite) begin
            prdata_d = {16'h0000, rd_d};
        end
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= prdata_d;
            pready <= pready_d;
            pslverr <= pslverr_d;
        end
    end
endmodule

/* File: dv/sipc_host.sv */
`timescale 1ns/100ps
// Host pin, pulled to the idle level while released
module sipc_host (
    input wire pin_o,
    input wire pin_oe_n,
    input wire pull,
    output wire level
);
    assign level = pin_oe_n ? pull : pin_o;
endmodule

/* File: dv/sipc_properties.sv */
`timescale 1ns/100ps
module sipc_properties (
    input wire clk,
    input wire reset_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    input wire first_slot_evt,
    input wire second_slot_evt,
    input wire irq_q,
    input wire pin_zero_o,
    input wire pin_zero_oe_n,
    input wire pin_one_o,
    input wire pin_one_oe_n
);
    reg [15:0] cfg_q;
    reg [15:0] prev_q;
    reg [15:0] mk_q;
    reg live_q;
    wire wr = psel && penable && pready && pwrite;
    wire st = live_q && (cfg_q == prev_q);
    always @(posedge clk) begin
        prev_q <= cfg_q;
        live_q <= reset_n;
        if (!reset_n) begin
            cfg_q <= 16'h0000;
            mk_q <= 16'h01FF;
        end else if (wr && paddr == 12'h008) begin
            cfg_q <= pwdata[15:0];
        end else if (wr && paddr == 12'h004) begin
            mk_q <= pwdata[15:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    chk_ready_next: assert property (psel && !penable |=> pready)
        else $error("pready late");
    chk_bad_addr: assert property (psel && !penable && paddr == 12'hFFC |=> pslverr)
        else $error("no slave error");
    chk_zero_pol: assert property (
        st && !pin_zero_oe_n |-> pin_zero_o == (irq_q ^ cfg_q[0])) else $error("pin0 level");
    chk_one_pol: assert property (
        st && !pin_one_oe_n |-> pin_one_o == (irq_q ^ cfg_q[8])) else $error("pin1 level");
    chk_zero_off: assert property (st && !cfg_q[2] |-> pin_zero_oe_n)
        else $error("pin0 driven");
    chk_zero_drive: assert property (
        st && cfg_q[2] |-> pin_zero_oe_n == (cfg_q[1] && !irq_q)) else $error("pin0 drive");
    chk_one_drive: assert property (st |-> pin_one_oe_n == (cfg_q[9] && !irq_q))
        else $error("pin1 drive");
    chk_first_irq: assert property (first_slot_evt && !mk_q[5] && !psel |-> ##2 irq_q)
        else $error("first irq lost");
    chk_second_irq: assert property (second_slot_evt && !mk_q[6] && !psel |-> ##2 irq_q)
        else $error("second irq lost");
    chk_masked_quiet: assert property (mk_q[6:5] == 2'h3 |=> !irq_q)
        else $error("masked irq");
endmodule
bind sipc_top sipc_properties i_chk (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .first_slot_evt(first_slot_evt), .second_slot_evt(second_slot_evt),
    .irq_q(irq_q), .pin_zero_o(pin_zero_o), .pin_zero_oe_n(pin_zero_oe_n),
    .pin_one_o(pin_one_o), .pin_one_oe_n(pin_one_oe_n));

/* File: dv/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    reg clk, reset_n, psel, penable, pwrite, fe, se, pz, po;
    reg [11:0] paddr;
    reg [31:0] pwdata, rd;
    reg er;
    reg [23:0] rows [0:5];
    wire [31:0] prdata;
    wire pready, pslverr, irq_q, zo, zoe, oo, ooe, lz, lo;
    integer failures, checks, cyc, i;
    sipc_top i_sipc_top (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .first_slot_evt(fe), .second_slot_evt(se), .irq_q(irq_q),
        .pin_zero_o(zo), .pin_zero_oe_n(zoe), .pin_one_o(oo), .pin_one_oe_n(ooe));
    sipc_host i_sipc_host_z (.pin_o(zo), .pin_oe_n(zoe), .pull(pz), .level(lz));
    sipc_host i_sipc_host_o (.pin_o(oo), .pin_oe_n(ooe), .pull(po), .level(lo));
    always #20 clk = ~clk;
    task finish_test;
        if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input [31:0] s, input [31:0] e);
        checks = checks + 1;
        if (s !== e) begin
            failures = failures + 1;
            $display("MISMATCH %0t seen %h want %h", $time, s, e);
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task pulse(input [1:0] e);
        @(posedge clk);
        {se, fe} <= e;
        @(posedge clk);
        {se, fe} <= 2'h0;
        @(posedge clk);
        #1;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures = failures + 1;
            finish_test;
        end
    end
    initial begin
        {clk, reset_n, psel, penable, pwrite, fe, se, pz, po, paddr, pwdata} = 0;
        {failures, checks, cyc} = 0;
        // Config, pins idle, pins active: {oe0, level0, oe1, level1}
        rows[0] = 24'h000089;
        rows[1] = 24'h000405;
        rows[2] = 24'h010550;
        rows[3] = 24'h0206A5;
        rows[4] = 24'h0307F0;
        rows[5] = 24'h0003CD;
        repeat (20) @(posedge clk);
        reset_n <= 1;
        apb(0, 12'h004, 0);
        chk(rd, 32'h01FF);
        pulse(2'h3);
        chk(irq_q, 0);
        apb(1, 12'h000, 0);
        apb(0, 12'h000, 0);
        chk(rd[6:5], 2'h3);
        apb(1, 12'h000, 32'h20);
        apb(0, 12'h000, 0);
        chk(rd[6:5], 2'h2);
        apb(1, 12'h000, 32'h40);
        apb(1, 12'h004, 32'h019F);
        pulse(2'h3);
        apb(1, 12'h000, 32'h40);
        chk(irq_q, 1);
        apb(1, 12'h000, 32'h20);
        repeat (2) @(posedge clk);
        chk(irq_q, 0);
        for (i = 0; i < 6; i = i + 1) begin
            pz <= rows[i][8];
            po <= rows[i][16];
            apb(1, 12'h008, rows[i][23:8]);
            @(posedge clk);
            #1;
            chk({zoe, lz, ooe, lo}, rows[i][7:4]);
            pulse(2'h1);
            chk({zoe, lz, ooe, lo}, rows[i][3:0]);
            apb(0, 12'h000, 0);
            chk(rd[5], 1);
            apb(1, 12'h000, 32'h20);
        end
        apb(0, 12'hFFC, 0);
        chk(er, 32'h00000001);
        chk(rd, 32'h00000000);
        apb(0, 12'h040, 32'h00000000);
        chk(rd, 32'h00000003);
        apb(1, 12'h040, 32'h00000003);
        apb(0, 12'h040, 32'h00000000);
        chk(rd, 32'h00000000);
        apb(1, 12'h018, 32'h0000FFFF);
        apb(0, 12'h018, 32'h00000000);
        chk(rd, 32'h00003F00);
        reset_n <= 0;
        @(posedge clk);
        reset_n <= 1;
        apb(0, 12'h008, 0);
        chk(rd, 0);
        apb(0, 12'h004, 32'h00000000);
        chk(rd, 32'h000001FF);
        finish_test;
    end
endmodule
